// File: common/ctp_pkg.sv
// Purpose: Shared constants and carriers for the conversion-time counter and prescaler
// Assumes: Register port is a simple byte-wide write/read strobe interface
// Notes: Offsets and fields follow the option register layout
package ctp_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] OPT_CTRL_ADDR = 8'h07;
  localparam logic [7:0] OPT_CTRL_RESET = 8'h40;
  localparam int CNT_ENA_BIT = 6;
  localparam int DIV_ENA_BIT = 3;
  localparam int DIV_SEL_LSB = 0;
  localparam int DIV_SEL_W = 3;
  // ==========================================================
  // Mode and sizes
  localparam logic [1:0] MODE_EDGE_BOUNDED = 2'h3;
  localparam int CLK_CNT_W = 24;
  localparam int RAW_W = 24;
  localparam int RES_W = 16;
  localparam logic [7:0] EDGES_RESET = 8'h01;

  typedef struct packed {
    logic cnt_ena;
    logic div_ena;
    logic [2:0] div_sel;
  } ctp_opt_type;

  typedef struct packed {
    logic [15:0] value;
    logic overflow;
  } ctp_result_type;
endpackage : ctp_pkg

// File: src/ctp_prescaler.sv
// Purpose: Divides a raw count by a power of two and flags overflow of the 16-bit result
// Assumes: Raw count is stable while valid is high
// Notes: Pure combinational shift
`timescale 1ns/1ps
module ctp_prescaler #(
  parameter int RAW_W = 24
) (
  // Control
  input wire ctp_pkg::ctp_opt_type opt_i,
  // Data
  input wire logic [RAW_W-1:0] raw_i,
  output ctp_pkg::ctp_result_type res_o
);
  // Overflow test needs bits above the 16-bit window
  if (RAW_W <= ctp_pkg::RES_W || RAW_W > 32)
  begin : g_bad_raw_w
    $error("ctp_prescaler: RAW_W must exceed the result width and stay within 32");
  end

  wire [3:0] shift_amt;
  wire [RAW_W-1:0] shifted;
  // Field value ignored unless divider enabled
  assign shift_amt = opt_i.div_ena ? ({1'b0, opt_i.div_sel} + 4'h1) : 4'h0;
  assign shifted = raw_i >> shift_amt;
  // Overflow when bits remain above the 16-bit window
  assign res_o.overflow = |shifted[RAW_W-1:ctp_pkg::RES_W];
  assign res_o.value = res_o.overflow ? 16'hffff : shifted[ctp_pkg::RES_W-1:0];
endmodule : ctp_prescaler

// File: src/ctp_edge_det.sv
// Purpose: Falling edge detector for the external trigger
// Assumes: Input already synchronous
// Notes: One-cycle pulse
`timescale 1ns/1ps
module ctp_edge_det (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Signal
  input wire logic sig_i,
  output logic fall_o
);
  logic prev_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_ff <= 1'b1;
    else
      prev_ff <= sig_i;
  end
  assign fall_o = prev_ff & ~sig_i;
endmodule : ctp_edge_det

// File: src/ctp_top.sv
// Purpose: Option register, externally bounded conversion clock counter and result prescaler
// Assumes: Register port strobes are synchronous, one cycle each
// Notes: Raw measurement counts arrive from the converter with a valid strobe
//
// How it works
// - In edge-bounded mode the conversion length comes from trigger pin pulses, not the time setting.
// - With counting disabled in that mode, no clocks are counted and the thermal result is invalid.
// - With counting enabled in that mode, clocks in the window are counted and thermal is valid.
// - The counted clocks are held in a readable 24-bit output.
// - With the divider disabled, results pass undivided.
// - With the divider enabled, raw counts are divided before entering the 16-bit result.
// - The division factor is two to the power of one plus the selection field.
// - The selection field is ignored while the divider is disabled.
// - Dividing widens the range and coarsens resolution by the same factor.
// - A suitable divider gives unsaturated results for 2^17 to 2^24 clock conversions.
// - Too small a divider that lets the result overflow sets the overflow flag.
// - Mode code 11 selects edge-bounded mode with start and end from the trigger pin.
// - A started conversion ends after a set number of extra falling edges.
`timescale 1ns/1ps
module ctp_top #(
  parameter int RAW_W = ctp_pkg::RAW_W,
  parameter int CNT_W = ctp_pkg::CLK_CNT_W
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // Mode and trigger
  input wire logic [1:0] MEASURE_KIND_SELECT_I,
  input wire logic [7:0] EDGE_COUNT_I,
  input wire logic EXT_TRIGGER_PIN_I,
  // Raw measurement
  input wire logic RAW_VALID_I,
  input wire logic [RAW_W-1:0] RAW_COUNT_I,
  // Results
  output logic CONV_ACTIVE_O,
  output logic CONV_DONE_O,
  output logic [CNT_W-1:0] CONVERSION_CLOCK_COUNT_RESULT_O,
  output logic THERMAL_VALID_O,
  output logic [15:0] RESULT_O,
  output logic RESULT_OVERFLOW_FLAG_O
);
  // ==========================================================
  // Parameter checks
  // Overflow needs bits above the 16-bit window; shifts are sized for 32 bits
  if (RAW_W < ctp_pkg::RES_W + 1)
  begin : g_raw_narrow
    $error("ctp_top: RAW_W must exceed the result width");
  end
  if (RAW_W > 32)
  begin : g_raw_wide
    $error("ctp_top: RAW_W above 32 is not supported");
  end
  if (CNT_W < 1)
  begin : g_cnt_narrow
    $error("ctp_top: CNT_W must be at least 1");
  end
  if (CNT_W > 32)
  begin : g_cnt_wide
    $error("ctp_top: CNT_W above 32 is not supported");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } ctp_state_type;

  // ==========================================================
  // Option register
  // Writable bits; the reserved ones always read back as zero
  localparam logic [7:0] CNT_ENA_MASK = 8'h01 << ctp_pkg::CNT_ENA_BIT;
  localparam logic [7:0] DIV_ENA_MASK = 8'h01 << ctp_pkg::DIV_ENA_BIT;
  localparam logic [7:0] DIV_SEL_MASK =
    8'(((1 << ctp_pkg::DIV_SEL_W) - 1) << ctp_pkg::DIV_SEL_LSB);
  localparam logic [7:0] OPT_WMASK = CNT_ENA_MASK | DIV_ENA_MASK | DIV_SEL_MASK;

  logic [7:0] opt_ff;
  logic [7:0] nxt_opt;
  wire opt_hit = (REG_ADDR_I == ctp_pkg::OPT_CTRL_ADDR);
  wire opt_wr = REG_WR_I && opt_hit;
  assign nxt_opt = opt_wr ? (REG_WDATA_I & OPT_WMASK) : opt_ff;
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      opt_ff <= ctp_pkg::OPT_CTRL_RESET;
    end
    else
    begin
      opt_ff <= nxt_opt;
    end
  end

  // ==========================================================
  // Option fields
  ctp_pkg::ctp_opt_type opt;
  assign opt.cnt_ena = opt_ff[ctp_pkg::CNT_ENA_BIT];
  assign opt.div_ena = opt_ff[ctp_pkg::DIV_ENA_BIT];
  assign opt.div_sel = opt_ff[ctp_pkg::DIV_SEL_LSB +: ctp_pkg::DIV_SEL_W];

  // ==========================================================
  // Trigger edges and mode decode
  wire trig_fall;
  ctp_edge_det u_edge (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .sig_i(EXT_TRIGGER_PIN_I),
    .fall_o(trig_fall)
  );

  wire edge_bounded_mode = (MEASURE_KIND_SELECT_I == ctp_pkg::MODE_EDGE_BOUNDED);
  // Zero edge count behaves as one
  wire [7:0] edges_needed = (EDGE_COUNT_I == 8'h00) ? ctp_pkg::EDGES_RESET : EDGE_COUNT_I;

  // ==========================================================
  // Window state
  ctp_state_type state_ff;
  ctp_state_type nxt_state;
  logic [7:0] edge_ff;
  logic [7:0] nxt_edge;
  logic [CNT_W-1:0] clk_cnt_ff;
  logic [CNT_W-1:0] nxt_clk_cnt;

  wire in_conv = (state_ff == ST_CONV);
  wire [7:0] edge_inc = edge_ff + 8'h01;
  wire [CNT_W-1:0] clk_cnt_inc = clk_cnt_ff + CNT_W'(1);
  // Leaving the mode drops the window, even on a closing edge, so no result is published
  wire conv_start = !in_conv && edge_bounded_mode && trig_fall;
  wire last_edge = in_conv && edge_bounded_mode && trig_fall &&
                   (edge_inc >= edges_needed);
  wire counting = in_conv && opt.cnt_ena;
  wire cnt_full = &clk_cnt_ff;

  // ==========================================================
  // Conversion state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (conv_start)
          nxt_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (!edge_bounded_mode)
          nxt_state = ST_IDLE;
        else if (last_edge)
          nxt_state = ST_DONE;
      end
      ST_DONE:
      begin
        if (conv_start)
          nxt_state = ST_CONV;
        else
          nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Edge and clock counters
  assign nxt_edge = conv_start ? 8'h00 :
                    (in_conv && trig_fall) ? edge_inc : edge_ff;
  // Counter saturates at full scale rather than wrapping, so a long window never reads short
  assign nxt_clk_cnt = conv_start ? '0 :
                       (counting && !cnt_full) ? clk_cnt_inc : clk_cnt_ff;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      edge_ff <= 8'h00;
    end
    else
    begin
      edge_ff <= nxt_edge;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      clk_cnt_ff <= '0;
    end
    else
    begin
      clk_cnt_ff <= nxt_clk_cnt;
    end
  end

  // ==========================================================
  // Published conversion results
  wire conv_end = last_edge;
  wire nxt_active = (nxt_state == ST_CONV);
  wire cnt_capture = conv_end && opt.cnt_ena;
  // Thermal flag drops at a start so a stale value never outlives its window
  wire therm_load = conv_start || conv_end;
  wire nxt_thermal = conv_end && opt.cnt_ena;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      CONV_ACTIVE_O <= 1'b0;
    end
    else
    begin
      CONV_ACTIVE_O <= nxt_active;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      CONV_DONE_O <= 1'b0;
    end
    else
    begin
      CONV_DONE_O <= conv_end;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      CONVERSION_CLOCK_COUNT_RESULT_O <= '0;
    end
    else if (cnt_capture)
    begin
      CONVERSION_CLOCK_COUNT_RESULT_O <= nxt_clk_cnt;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      THERMAL_VALID_O <= 1'b0;
    end
    else if (therm_load)
    begin
      THERMAL_VALID_O <= nxt_thermal;
    end
  end

  // ==========================================================
  // Result prescaler
  ctp_pkg::ctp_result_type pres;
  ctp_prescaler #(
    .RAW_W(RAW_W)
  ) u_pres (
    .opt_i(opt),
    .raw_i(RAW_COUNT_I),
    .res_o(pres)
  );

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      RESULT_O <= 16'h0000;
    end
    else if (RAW_VALID_I)
    begin
      RESULT_O <= pres.value;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      RESULT_OVERFLOW_FLAG_O <= 1'b0;
    end
    else if (RAW_VALID_I)
    begin
      RESULT_OVERFLOW_FLAG_O <= pres.overflow;
    end
  end

  // ==========================================================
  // Register readback
  // Read data follows the address by one cycle; other addresses read zero
  wire [7:0] nxt_rdata = opt_hit ? opt_ff : 8'h00;
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      REG_RDATA_O <= 8'h00;
    end
    else
    begin
      REG_RDATA_O <= nxt_rdata;
    end
  end
endmodule : ctp_top

// File: testbench/ctp_properties.sv
// Purpose: Port checker for ctp_top
// Assumes: Option writes land outside windows
// Notes: Bound at file foot
`timescale 1ns/1ps
module ctp_chk #(
  parameter int RAW_W = 24,
  parameter int CNT_W = 24
) (
  // Inputs
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [1:0] MEASURE_KIND_SELECT_I,
  input wire logic RAW_VALID_I,
  input wire logic [RAW_W-1:0] RAW_COUNT_I,
  // Outputs
  input wire logic [7:0] REG_RDATA_O,
  input wire logic CONV_ACTIVE_O,
  input wire logic CONV_DONE_O,
  input wire logic [CNT_W-1:0] CONVERSION_CLOCK_COUNT_RESULT_O,
  input wire logic THERMAL_VALID_O,
  input wire logic [15:0] RESULT_O,
  input wire logic RESULT_OVERFLOW_FLAG_O
);
  // ====
  // Mirrors of option byte, window length and quotient
  logic [7:0] opt_ff;
  logic [CNT_W-1:0] len_ff;
  logic [RAW_W-1:0] quo_ff;
  wire wr_opt = REG_WR_I && REG_ADDR_I == 8'h07;
  wire [3:0] shift = opt_ff[3] ? {1'b0, opt_ff[2:0]} + 4'h1 : 4'h0;
  wire [RAW_W-1:0] quo = RAW_COUNT_I >> shift;
  wire big = |quo_ff[RAW_W-1:16];
  always_ff @(posedge REF_CLK_I)
  begin
    opt_ff <= RST_I ? 8'h40 : wr_opt ? REG_WDATA_I & 8'h4f : opt_ff;
    len_ff <= CONV_ACTIVE_O ? len_ff + CNT_W'(1) : '0;
    quo_ff <= quo;
  end
  // ====
  // Properties
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_close;
    CONV_ACTIVE_O ##1 CONV_DONE_O;
  endsequence
  property p_on;
    s_close ##0 opt_ff[6] |-> THERMAL_VALID_O && CONVERSION_CLOCK_COUNT_RESULT_O == len_ff;
  endproperty
  a_on: assert property (p_on)
    else $error("count or thermal wrong at window end");
  property p_off;
    s_close ##0 !opt_ff[6] |-> !THERMAL_VALID_O && $stable(CONVERSION_CLOCK_COUNT_RESULT_O);
  endproperty
  a_off: assert property (p_off)
    else $error("disabled window changed count or thermal");
  property p_start;
    $rose(CONV_ACTIVE_O) |-> !THERMAL_VALID_O;
  endproperty
  a_start: assert property (p_start)
    else $error("thermal not cleared at window start");
  property p_pulse;
    CONV_DONE_O |-> !CONV_ACTIVE_O && $past(CONV_ACTIVE_O) ##1 !CONV_DONE_O;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done not a single pulse after a window");
  property p_mode;
    (MEASURE_KIND_SELECT_I != 2'h3) [*2] |-> !CONV_ACTIVE_O && !CONV_DONE_O;
  endproperty
  a_mode: assert property (p_mode)
    else $error("window outside edge-bounded mode");
  property p_res;
    RAW_VALID_I |=> RESULT_O == (big ? 16'hffff : quo_ff[15:0]);
  endproperty
  a_res: assert property (p_res)
    else $error("divided result wrong");
  property p_ovf;
    RAW_VALID_I |=> RESULT_OVERFLOW_FLAG_O == big;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag wrong");
  property p_rd;
    REG_ADDR_I == 8'h07 |=> REG_RDATA_O == $past(opt_ff);
  endproperty
  a_rd: assert property (p_rd)
    else $error("option readback wrong");
endmodule : ctp_chk

bind ctp_top ctp_chk #(.RAW_W(RAW_W), .CNT_W(CNT_W)) u_chk (.*);

// File: testbench/ctp_trig_src.sv
// Purpose: Trigger pulse source on the far side
// Assumes: Pin idles high between bursts
// Notes: Falls spaced gap cycles apart
`timescale 1ns/1ps
module ctp_trig_src (
  // Clock and control
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] falls_i,
  // Pin
  output logic pin_o
);
  initial pin_o = 1'b1;
  always @(posedge clk_i)
  begin
    if (fire_i)
    begin
      repeat (falls_i)
      begin
        pin_o <= 1'b0;
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (gap_i - 8'h01) @(posedge clk_i);
      end
    end
  end
endmodule : ctp_trig_src

// File: testbench/testbench.sv
// Purpose: Directed bench for ctp_top
// Assumes: Trigger source model drives the pin
// Notes: Short windows keep the run brief
`timescale 1ns/1ps
module testbench;
  // ====
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [7:0] edges = 8'h01;
  logic [7:0] gap = 8'h04;
  logic [7:0] falls = 8'h02;
  logic fire = 1'b0;
  logic vld = 1'b0;
  logic seen = 1'b0;
  logic [23:0] raw = 24'h000000;
  logic [7:0] rdata;
  logic pin, act, done, therm, ovf;
  logic [23:0] cnt, q;
  logic [15:0] res;
  int err_count = 0;
  int compares = 0;
  initial forever #12.5 clk = ~clk;
  ctp_top uut (.REF_CLK_I(clk), .RST_I(rst), .REG_WR_I(reg_wr), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .MEASURE_KIND_SELECT_I(mode),
    .EDGE_COUNT_I(edges), .EXT_TRIGGER_PIN_I(pin), .RAW_VALID_I(vld), .RAW_COUNT_I(raw),
    .CONV_ACTIVE_O(act), .CONV_DONE_O(done), .CONVERSION_CLOCK_COUNT_RESULT_O(cnt),
    .THERMAL_VALID_O(therm), .RESULT_O(res), .RESULT_OVERFLOW_FLAG_O(ovf));
  ctp_trig_src u_src (.clk_i(clk), .fire_i(fire), .gap_i(gap), .falls_i(falls), .pin_o(pin));
  // ====
  // Tasks
  task close_out;
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task put_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : put_reg
  task get_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("rdata", {16'h0000, e}, {16'h0000, rdata});
  endtask : get_reg
  task put_raw(input logic [23:0] v, input logic [15:0] e, input logic o);
    @(posedge clk);
    vld <= 1'b1;
    raw <= v;
    @(posedge clk);
    vld <= 1'b0;
    #1 chk("result", {8'h00, e}, {8'h00, res});
    chk("overflow", {23'h0, o}, {23'h0, ovf});
  endtask : put_raw
  task fire_src(input logic [7:0] n, input logic [7:0] g);
    @(posedge clk);
    edges <= n;
    gap <= g;
    falls <= (n == 8'h00) ? 8'h02 : n + 8'h01;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask : fire_src
  task run_win(input logic [7:0] n, input logic [7:0] g, input logic [23:0] c, input logic t);
    fire_src(n, g);
    for (int i = 0; i < 2000 && done !== 1'b1; i++)
      @(posedge clk) #1;
    if (done !== 1'b1)
    begin
      err_count++;
      close_out();
    end
    chk("count", c, cnt);
    chk("thermal", {23'h0, t}, {23'h0, therm});
    repeat (12) @(posedge clk);
  endtask : run_win
  // ====
  // Sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    get_reg(8'h07, 8'h40);
    put_reg(8'h07, 8'hff);
    put_reg(8'h08, 8'h00);
    get_reg(8'h07, 8'h4f);
    get_reg(8'h08, 8'h00);
    put_reg(8'h07, 8'h47);
    put_raw(24'h00fedc, 16'hfedc, 1'b0);
    put_raw(24'h010000, 16'hffff, 1'b1);
    for (int s = 0; s < 8; s++)
    begin
      put_reg(8'h07, 8'h48 | 8'(s));
      q = 24'hfedcba >> (s + 1);
      put_raw(24'hfedcba, (q > 24'h00ffff) ? 16'hffff : q[15:0], q > 24'h00ffff);
    end
    @(posedge clk);
    mode <= 2'h3;
    run_win(8'h01, 8'h04, 24'h000004, 1'b1);
    run_win(8'h03, 8'h07, 24'h000015, 1'b1);
    run_win(8'h00, 8'h05, 24'h000005, 1'b1);
    put_reg(8'h07, 8'h0f);
    run_win(8'h02, 8'h06, 24'h000005, 1'b0);
    put_reg(8'h07, 8'h4f);
    run_win(8'h02, 8'h03, 24'h000006, 1'b1);
    fire_src(8'h05, 8'h0a);
    repeat (15) @(posedge clk);
    mode <= 2'h0;
    repeat (80) @(posedge clk) #1 seen = seen | done;
    chk("abort", 24'h000000, {22'h0, seen, act});
    close_out();
  end
endmodule : testbench
